// [hw/mrsc_pkg.sv]
// constants, register map and types shared by the reset sequencer files
package mrsc_pkg;

  // ********************************************************************
  // clocking and start-up timing
  // ********************************************************************
  localparam longint unsigned CLK_HZ         = 100_000_000;
  localparam longint unsigned SLOW_RC_HZ     = 32_000;
  localparam longint unsigned US_PER_S       = 1_000_000;
  localparam longint unsigned STARTUP_PIN_US = 16_700;  // 16.7 ms after pin, por and watchdog
  localparam longint unsigned STARTUP_LVR_US = 50_000;  // 50 ms after an undervoltage reset
  localparam int              DIV_W          = 12;
  localparam int              TICK_W         = 11;

  // system clocks per slow rc period, the slow rate is an enable pulse
  localparam logic [DIV_W-1:0]  SLOW_RC_DIV_D   = DIV_W'(CLK_HZ / SLOW_RC_HZ);
  // least times round up to whole slow rc periods
  localparam logic [TICK_W-1:0] STARTUP_PIN_D   =
    TICK_W'((STARTUP_PIN_US * SLOW_RC_HZ + US_PER_S - 1) / US_PER_S);
  localparam logic [TICK_W-1:0] STARTUP_LVR_D   =
    TICK_W'((STARTUP_LVR_US * SLOW_RC_HZ + US_PER_S - 1) / US_PER_S);
  localparam logic [TICK_W-1:0] UV_MIN_TICKS_D  = 11'h004;  // undervoltage_min_duration
  localparam logic [TICK_W-1:0] FIRE_TICKS      = 11'h002;  // 2~3 slow periods, low end taken
  localparam logic [TICK_W-1:0] ONE_TICK        = 11'h001;

  // ********************************************************************
  // register map, byte addresses on the avalon slave
  // ********************************************************************
  localparam int              ADDR_W       = 5;
  localparam logic [ADDR_W-1:0] ADR_PINSEL = 5'h00;  // reset_pin_select
  localparam logic [ADDR_W-1:0] ADR_SYSTEM_MODE_CONTROL_1  = 5'h04;  // system_mode_control_1
  localparam logic [ADDR_W-1:0] ADR_IRQ_ST = 5'h08;
  localparam logic [ADDR_W-1:0] ADR_IRQ_MK = 5'h0C;
  localparam logic [ADDR_W-1:0] ADR_CAUSE  = 5'h10;

  localparam logic [7:0] PINSEL_GPIO  = 8'h55;
  localparam logic [7:0] PINSEL_RESET = 8'hAA;
  localparam logic [7:0] PINSEL_POR   = 8'h55;

  localparam int SM_SYSKEEP = 7;
  localparam int SM_RSVD    = 3;
  localparam int SM_UVF     = 2;
  localparam int SM_WRF     = 0;

  localparam logic [4:0] WDT_EN_ON  = 5'h0A;
  localparam logic [4:0] WDT_EN_OFF = 5'h15;

  localparam int IRQ_PIN  = 0;
  localparam int IRQ_UV   = 1;
  localparam int IRQ_WDTO = 2;
  localparam int IRQ_WCTL = 3;
  localparam int IRQ_RUN  = 4;
  localparam int IRQ_W    = 5;

  localparam int CA_TO    = 0;  // cause register: timeout_flag
  localparam int CA_KIND  = 4;  // cause register: last reset kind, 3 bits
  localparam int CA_STATE = 8;  // cause register: sequencer state, 2 bits

  typedef enum logic [1:0] {ST_RESET, ST_DELAY, ST_RUN} mrsc_state_t;
  typedef enum logic [2:0] {K_POR, K_PIN, K_UV, K_WDTO, K_WCTL} mrsc_kind_t;

endpackage : mrsc_pkg

// [hw/mrsc_tmr_if.sv]
// interface between the sequencer and one slow-tick timer
interface mrsc_tmr_if
  import mrsc_pkg::*;
  ();
  logic              clear;  // held high keeps the timer at zero
  logic              tick;   // slow rc enable pulse
  logic [TICK_W-1:0] limit;  // periods to count, at least one
  logic              done;   // level, high once limit periods passed
  modport ctrl (output clear, output tick, output limit, input done);
  modport tmr  (input clear, input tick, input limit, output done);
endinterface : mrsc_tmr_if

// [hw/mrsc_tick_timer.sv]
// counter of slow rc periods with a terminal count and a sticky done level
module mrsc_tick_timer
  import mrsc_pkg::*;
  (
  input wire logic   clk,
  input wire logic   rst,
  mrsc_tmr_if.tmr    t
  );

  logic [TICK_W-1:0] cnt_r;
  logic              done_r;

  // count ticks while not cleared, stop and hold done at the limit
  always_ff @(posedge clk) begin
    if (rst || t.clear) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (t.tick && !done_r) begin
      if (cnt_r == t.limit - ONE_TICK) begin
        done_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + ONE_TICK;
      end
    end
  end

  assign t.done = done_r;

endmodule // mrsc_tick_timer

// [hw/mrsc_reset_ctrl.sv]
// reset sequencer: reset sources, start-up delays, pin select and flags
// Function
// - power-on reset forces the program counter to zero.
// - power-on reset presets every port data and direction register to ones.
// - shared pin in reset mode driven low resets device and clears counter.
// - pin reset keeps some registers, only power-on gives a cold init.
// - after pin release hold execution for the 16.7 ms start-up delay; the delay starts once the select restore ends the pin reset.
// - pin select 55h gives general io, AAh gives reset input, others forbidden.
// - every reset restores pin select except the watchdog time-out reset.
// - undervoltage reset active in normal and slow, disabled in sleep or idle.
// - undervoltage reset resets device and sets undervoltage flag.
// - undervoltage shorter than the minimum duration is ignored.
// - recognised undervoltage asserts reset within 2~3 slow rc periods.
// - after undervoltage reset apply the 50 ms start-up delay.
// - software clears undervoltage flag by writing zero, writing one ignored.
// - watchdog time-out resets with the 16.7 ms start-up delay and also sets timeout flag.
// - invalid watchdog enable field sets control reset flag, software clears it.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
module mrsc_reset_ctrl
  import mrsc_pkg::*;
  #(
  parameter logic [DIV_W-1:0]  SLOW_RC_DIV  = SLOW_RC_DIV_D,
  parameter logic [TICK_W-1:0] STARTUP_PIN  = STARTUP_PIN_D,
  parameter logic [TICK_W-1:0] STARTUP_LVR  = STARTUP_LVR_D,
  parameter logic [TICK_W-1:0] UV_MIN_TICKS = UV_MIN_TICKS_D
  )
  (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              EXT_RESET_N_PIN,
  input  wire logic              UNDERVOLTAGE_DET,
  input  wire logic              SLEEP_IDLE,
  input  wire logic              WDT_TIMEOUT,
  input  wire logic              WDT_FIELD_WR,
  input  wire logic [4:0]        WDT_FIELD_VAL,
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [31:0]       AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  output logic                   CPU_HOLD,
  output logic                   PC_CLEAR,
  output logic                   PORT_PRESET,
  output logic                   COLD_INIT,
  output logic                   TIMEOUT_FLAG,
  output logic                   PIN_RESET_MODE,
  output logic                   PORT_A_BIT7_GPIO,
  output logic                   IDLE_SYSCLK_KEEP,
  output logic                   IRQ
  );

  // ********************************************************************
  // declarations
  // ********************************************************************
  mrsc_state_t       state_r, state_nxt;
  mrsc_kind_t        kind_r, kind_nxt, cause_kind;
  logic [DIV_W-1:0]  div_cnt_r;
  logic              slow_tick_r;
  logic [1:0]        sync1_r, sync2_r;     // bit 0 reset pin, bit 1 undervoltage
  logic              wait_r;
  logic [31:0]       rdata_r;
  logic [7:0]        pinsel_r;
  logic              syskeep_r, rsvd_r, uvf_r, wrf_r, to_r;
  logic              wctl_pend_r;
  logic [IRQ_W-1:0]  irq_st_r, irq_mk_r, irq_ev;
  logic              req, wr_en, rd_take;
  logic              pin_low, uv_live, uv_fire, wctl_fire, wdto_fire;
  logic              cause_any, rst_enter, restore_sel;
  logic [31:0]       rd_mux;

  mrsc_tmr_if u_start_if ();
  mrsc_tmr_if u_uvmin_if ();
  mrsc_tmr_if u_uvfire_if ();
  mrsc_tmr_if u_wfire_if ();

  // ********************************************************************
  // slow rc rate and pin synchronisers
  // ********************************************************************
  // one enable pulse per slow rc period keeps the design on one clock
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      div_cnt_r   <= '0;
      slow_tick_r <= 1'b0;
    end else if (div_cnt_r == SLOW_RC_DIV - DIV_W'(1)) begin
      div_cnt_r   <= '0;
      slow_tick_r <= 1'b1;
    end else begin
      div_cnt_r   <= div_cnt_r + DIV_W'(1);
      slow_tick_r <= 1'b0;
    end
  end

  // two flops before anything looks at the pin or the comparator
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sync1_r <= 2'h1;  // pin idles high, no undervoltage
      sync2_r <= 2'h1;
    end else begin
      sync1_r <= {UNDERVOLTAGE_DET, EXT_RESET_N_PIN};
      sync2_r <= sync1_r;
    end
  end

  // ********************************************************************
  // reset sources
  // ********************************************************************
  // the pin only resets while the select register names it as reset input
  assign pin_low = (pinsel_r == PINSEL_RESET) && !sync2_r[0];
  // comparator is ignored in sleep or idle
  assign uv_live = sync2_r[1] && !SLEEP_IDLE;

  // persistence filter: must last beyond the minimum duration
  assign u_uvmin_if.clear = !uv_live;
  assign u_uvmin_if.tick  = slow_tick_r;
  assign u_uvmin_if.limit = UV_MIN_TICKS + ONE_TICK;

  // recognised condition reaches the core two slow periods later
  assign u_uvfire_if.clear = !(u_uvmin_if.done && uv_live);
  assign u_uvfire_if.tick  = slow_tick_r;
  assign u_uvfire_if.limit = FIRE_TICKS;
  assign uv_fire           = u_uvfire_if.done;

  // invalid enable field waits the same two periods before reset
  assign u_wfire_if.clear = !wctl_pend_r;
  assign u_wfire_if.tick  = slow_tick_r;
  assign u_wfire_if.limit = FIRE_TICKS;
  assign wctl_fire        = u_wfire_if.done;

  // time-out only counts as a warm reset while the core runs awake
  assign wdto_fire = WDT_TIMEOUT && (state_r == ST_RUN) && !SLEEP_IDLE;

  // invalid enable field arms a pending reset, cleared once it fires
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wctl_pend_r <= 1'b0;
    end else if (wctl_fire) begin
      wctl_pend_r <= 1'b0;
    end else if (WDT_FIELD_WR && (WDT_FIELD_VAL != WDT_EN_ON)
                 && (WDT_FIELD_VAL != WDT_EN_OFF)) begin
      wctl_pend_r <= 1'b1;
    end
  end

  // priority of simultaneous sources: pin, undervoltage, control, time-out
  always_comb begin
    cause_any  = 1'b1;
    cause_kind = K_PIN;
    if (pin_low) begin
      cause_kind = K_PIN;
    end else if (uv_fire) begin
      cause_kind = K_UV;
    end else if (wctl_fire) begin
      cause_kind = K_WCTL;
    end else if (wdto_fire) begin
      cause_kind = K_WDTO;
    end else begin
      cause_any = 1'b0;
    end
  end

  assign rst_enter   = cause_any && (state_r != ST_RESET);
  assign restore_sel = cause_any && (cause_kind != K_WDTO);

  // ********************************************************************
  // sequencer
  // ********************************************************************
  // start-up timer stays cleared through the whole reset phase
  assign u_start_if.clear = (state_r == ST_RESET);
  assign u_start_if.tick  = slow_tick_r;
  assign u_start_if.limit = (kind_r == K_UV) ? STARTUP_LVR : STARTUP_PIN;

  // a live source holds reset, its release starts the delay
  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    if (cause_any) begin
      state_nxt = ST_RESET;
      kind_nxt  = cause_kind;
    end else begin
      unique case (state_r)
        ST_RESET: state_nxt = ST_DELAY;
        ST_DELAY: if (u_start_if.done) state_nxt = ST_RUN;
        ST_RUN:   state_nxt = ST_RUN;
      endcase
    end
  end

  // power-on reset is the synchronous system reset itself
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= ST_RESET;
      kind_r  <= K_POR;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
    end
  end

  // ********************************************************************
  // avalon slave
  // ********************************************************************
  // fixed answer: waitrequest high in the first cycle, low in the second
  assign req     = AVS_READ || AVS_WRITE;
  assign wr_en   = AVS_WRITE && !wait_r && AVS_BYTEENABLE[0];
  assign rd_take = AVS_READ && wait_r;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !(req && wait_r);
    end
  end

  // unmapped addresses read as zero and ignore writes
  always_comb begin
    rd_mux = '0;
    unique case (AVS_ADDRESS)
      ADR_PINSEL: rd_mux[7:0] = pinsel_r;
      ADR_SYSTEM_MODE_CONTROL_1: begin
        rd_mux[SM_SYSKEEP] = syskeep_r;
        rd_mux[SM_RSVD]    = rsvd_r;
        rd_mux[SM_UVF]     = uvf_r;
        rd_mux[SM_WRF]     = wrf_r;
      end
      ADR_IRQ_ST: rd_mux[IRQ_W-1:0] = irq_st_r;
      ADR_IRQ_MK: rd_mux[IRQ_W-1:0] = irq_mk_r;
      ADR_CAUSE: begin
        rd_mux[CA_TO]              = to_r;
        rd_mux[CA_KIND+:3]         = kind_r;
        rd_mux[CA_STATE+:2]        = state_r;
      end
      default: rd_mux = '0;
    endcase
  end

  // read data sampled on the first cycle so they stand on the answer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_r <= rd_mux;
    end
  end

  // ********************************************************************
  // registers
  // ********************************************************************
  // any byte may be stored; only 55h and AAh give the pin a function
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pinsel_r <= PINSEL_POR;
    end else if (restore_sel) begin
      pinsel_r <= PINSEL_POR;
    end else if (wr_en && AVS_ADDRESS == ADR_PINSEL) begin
      pinsel_r <= AVS_WRITEDATA[7:0];
    end
  end

  // plain read/write bits of the mode register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      syskeep_r <= 1'b0;
      rsvd_r    <= 1'b0;
    end else if (wr_en && AVS_ADDRESS == ADR_SYSTEM_MODE_CONTROL_1) begin
      syskeep_r <= AVS_WRITEDATA[SM_SYSKEEP];
      rsvd_r    <= AVS_WRITEDATA[SM_RSVD];
    end
  end

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      uvf_r <= 1'b0;
      wrf_r <= 1'b0;
    end else begin
      if (rst_enter && cause_kind == K_UV) begin
        uvf_r <= 1'b1;
      end else if (wr_en && AVS_ADDRESS == ADR_SYSTEM_MODE_CONTROL_1 && !AVS_WRITEDATA[SM_UVF]) begin
        uvf_r <= 1'b0;
      end
      if (wctl_fire) begin
        wrf_r <= 1'b1;
      end else if (wr_en && AVS_ADDRESS == ADR_SYSTEM_MODE_CONTROL_1 && !AVS_WRITEDATA[SM_WRF]) begin
        wrf_r <= 1'b0;
      end
    end
  end

  // timeout flag survives warm resets, write zero clears it
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      to_r <= 1'b0;
    end else if (wdto_fire) begin
      to_r <= 1'b1;
    end else if (wr_en && AVS_ADDRESS == ADR_CAUSE && !AVS_WRITEDATA[CA_TO]) begin
      to_r <= 1'b0;
    end
  end

  // ********************************************************************
  // interrupts
  // ********************************************************************
  always_comb begin
    irq_ev           = '0;
    irq_ev[IRQ_PIN]  = rst_enter && cause_kind == K_PIN;
    irq_ev[IRQ_UV]   = rst_enter && cause_kind == K_UV;
    irq_ev[IRQ_WDTO] = rst_enter && cause_kind == K_WDTO;
    irq_ev[IRQ_WCTL] = rst_enter && cause_kind == K_WCTL;
    irq_ev[IRQ_RUN]  = state_r == ST_DELAY && state_nxt == ST_RUN;
  end

  // sticky status, write one clears, new events win over the clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_st_r <= '0;
    end else if (wr_en && AVS_ADDRESS == ADR_IRQ_ST) begin
      irq_st_r <= (irq_st_r & ~AVS_WRITEDATA[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_st_r <= irq_st_r | irq_ev;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_mk_r <= '0;
    end else if (wr_en && AVS_ADDRESS == ADR_IRQ_MK) begin
      irq_mk_r <= AVS_WRITEDATA[IRQ_W-1:0];
    end
  end

  // ********************************************************************
  // timers and outputs
  // ********************************************************************
  mrsc_tick_timer u_start (.clk(CLK), .rst(SYS_RST), .t(u_start_if));
  mrsc_tick_timer u_uvmin (.clk(CLK), .rst(SYS_RST), .t(u_uvmin_if));
  mrsc_tick_timer u_uvfire (.clk(CLK), .rst(SYS_RST), .t(u_uvfire_if));
  mrsc_tick_timer u_wfire (.clk(CLK), .rst(SYS_RST), .t(u_wfire_if));

  // core controls lag the sequencer state by one cycle, all from flops
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      CPU_HOLD    <= 1'b1;
      PC_CLEAR    <= 1'b1;
      PORT_PRESET <= 1'b1;
      COLD_INIT   <= 1'b1;
    end else begin
      CPU_HOLD    <= state_r != ST_RUN;
      PC_CLEAR    <= state_r == ST_RESET;
      PORT_PRESET <= state_r == ST_RESET;
      COLD_INIT   <= state_r == ST_RESET && kind_r == K_POR;
    end
  end

  // mirrors of register state for the rest of the chip
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      TIMEOUT_FLAG     <= 1'b0;
      PIN_RESET_MODE   <= 1'b0;
      PORT_A_BIT7_GPIO <= 1'b0;
      IDLE_SYSCLK_KEEP <= 1'b0;
      IRQ              <= 1'b0;
      AVS_WAITREQUEST  <= 1'b1;
    end else begin
      TIMEOUT_FLAG     <= to_r;
      PIN_RESET_MODE   <= pinsel_r == PINSEL_RESET;
      PORT_A_BIT7_GPIO <= pinsel_r == PINSEL_GPIO;
      IDLE_SYSCLK_KEEP <= syskeep_r;
      IRQ              <= |(irq_st_r & irq_mk_r);
      AVS_WAITREQUEST  <= !(req && wait_r);
    end
  end

  assign AVS_READDATA = rdata_r;

endmodule // mrsc_reset_ctrl

// [tb/mrsc_reset_ctrl_properties.sv]
// concurrent checks on the ports of the reset sequencer
module mrsc_reset_ctrl_checker
  import mrsc_pkg::*;
  #(
  parameter logic [DIV_W-1:0]  SLOW_RC_DIV  = SLOW_RC_DIV_D,
  parameter logic [TICK_W-1:0] UV_MIN_TICKS = UV_MIN_TICKS_D
  )
  (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic EXT_RESET_N_PIN,
  input wire logic UNDERVOLTAGE_DET,
  input wire logic SLEEP_IDLE,
  input wire logic WDT_TIMEOUT,
  input wire logic CPU_HOLD,
  input wire logic PC_CLEAR,
  input wire logic PORT_PRESET,
  input wire logic COLD_INIT,
  input wire logic PIN_RESET_MODE,
  input wire logic PORT_A_BIT7_GPIO
  );
  // worst case from steady undervoltage to reset phase, sync and output lag included
  localparam int UV_LIM = (int'(UV_MIN_TICKS) + 4) * int'(SLOW_RC_DIV) + 8;
  int uv_cnt_r;
  // ********************************************************************
  // helper counter and checks
  // ********************************************************************
  // length of the current undervoltage stretch, sleep hides it
  always_ff @(posedge CLK) begin
    if (SYS_RST || !UNDERVOLTAGE_DET || SLEEP_IDLE) begin
      uv_cnt_r <= 0;
    end else if (uv_cnt_r < UV_LIM) begin
      uv_cnt_r <= uv_cnt_r + 1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  por_hold_a: assert property (disable iff (1'b0)
    SYS_RST |=> CPU_HOLD && PC_CLEAR && PORT_PRESET && COLD_INIT) else $error("por not forced");
  phase_tie_a: assert property (
    PC_CLEAR |-> CPU_HOLD && PORT_PRESET) else $error("reset phase outputs apart");
  pin_reset_a: assert property (
    $fell(EXT_RESET_N_PIN) && PIN_RESET_MODE |-> ##[2:6] PC_CLEAR) else $error("pin reset missed");
  pin_restore_a: assert property (
    PIN_RESET_MODE && !EXT_RESET_N_PIN |-> ##[2:6] PORT_A_BIT7_GPIO) else $error("select kept");
  wdt_keep_a: assert property (
    WDT_TIMEOUT && PIN_RESET_MODE && EXT_RESET_N_PIN && !CPU_HOLD |=> PIN_RESET_MODE[*6])
    else $error("select lost on time-out");
  cold_warm_a: assert property (
    $rose(PC_CLEAR) && !$past(SYS_RST) |-> !COLD_INIT) else $error("warm reset went cold");
  hold_min_a: assert property (
    $fell(PC_CLEAR) |-> CPU_HOLD[*6]) else $error("start-up delay too short");
  uv_fire_a: assert property (
    uv_cnt_r == UV_LIM |-> PC_CLEAR) else $error("undervoltage reset late");
  uv_glitch_a: assert property (
    $fell(UNDERVOLTAGE_DET) && uv_cnt_r <= 3 && !CPU_HOLD |=> !PC_CLEAR[*8])
    else $error("short undervoltage reset");
  pin_cov: cover property (PIN_RESET_MODE && !EXT_RESET_N_PIN);
  uv_cov: cover property (uv_cnt_r == UV_LIM);
  wdt_cov: cover property (WDT_TIMEOUT && !CPU_HOLD);
endmodule // mrsc_reset_ctrl_checker

bind mrsc_reset_ctrl mrsc_reset_ctrl_checker #(.SLOW_RC_DIV(SLOW_RC_DIV),
  .UV_MIN_TICKS(UV_MIN_TICKS)) chk (.CLK(CLK), .SYS_RST(SYS_RST),
  .EXT_RESET_N_PIN(EXT_RESET_N_PIN), .UNDERVOLTAGE_DET(UNDERVOLTAGE_DET),
  .SLEEP_IDLE(SLEEP_IDLE), .WDT_TIMEOUT(WDT_TIMEOUT), .CPU_HOLD(CPU_HOLD),
  .PC_CLEAR(PC_CLEAR), .PORT_PRESET(PORT_PRESET), .COLD_INIT(COLD_INIT),
  .PIN_RESET_MODE(PIN_RESET_MODE), .PORT_A_BIT7_GPIO(PORT_A_BIT7_GPIO));

// [tb/mrsc_supply_model.sv]
// model of the external reset network and the supply monitor
module mrsc_supply_model (
  input  wire logic clk,
  output logic      reset_n,
  output logic      uv_low
  );
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************************
  // pin and supply levels
  // ********************************************************************
  // the pull-up keeps the pin high and the supply is good until told otherwise
  initial begin
    reset_n = 1'b1;
    uv_low = 1'b0;
  end
  // levels change only just after a rising edge, like the rest of the bench
  task automatic set_pin(input logic v);
    @(posedge clk);
    reset_n <= v;
  endtask
  task automatic set_uv(input logic v);
    @(posedge clk);
    uv_low <= v;
  endtask
endmodule // mrsc_supply_model

// [tb/mrsc_reset_ctrl_bench.sv]
// self-checking bench for the reset sequencer
module mrsc_reset_ctrl_bench
  import mrsc_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV  = 4;
  localparam int SPIN = 3;
  localparam int SLVR = 8;
  logic        CLK = 1'b0;
  logic        sys_rst, sleep, wdt_to, fwr, rd, wr, wreq, hold, pcc, pp, cold, tof;
  logic        pmode, gpio, irq, keep;
  logic [3:0]  be;
  logic [4:0]  fval, adr;
  logic [31:0] wd, rdata, q;
  wire         pin_n, uv;
  int          fail_count = 0;
  int          compares = 0;
  int          n;
  // ********************************************************************
  // clock, partner and design
  // ********************************************************************
  // 100 MHz system clock
  always #5 CLK = ~CLK;
  mrsc_supply_model sup (.clk(CLK), .reset_n(pin_n), .uv_low(uv));
  // short counts keep the run brief, expectations scale from the same values
  mrsc_reset_ctrl #(.SLOW_RC_DIV(12'h004), .STARTUP_PIN(11'h003), .STARTUP_LVR(11'h008),
    .UV_MIN_TICKS(11'h001)) DUT (.CLK(CLK), .SYS_RST(sys_rst), .EXT_RESET_N_PIN(pin_n),
    .UNDERVOLTAGE_DET(uv), .SLEEP_IDLE(sleep), .WDT_TIMEOUT(wdt_to), .WDT_FIELD_WR(fwr),
    .WDT_FIELD_VAL(fval), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .CPU_HOLD(hold), .PC_CLEAR(pcc), .PORT_PRESET(pp),
    .COLD_INIT(cold), .TIMEOUT_FLAG(tof), .PIN_RESET_MODE(pmode),
    .PORT_A_BIT7_GPIO(gpio), .IDLE_SYSCLK_KEEP(keep), .IRQ(irq));
  // ********************************************************************
  // shared tasks
  // ********************************************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low; read data lands in q
  task bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wd <= d;
    @(posedge CLK);
    while (wreq !== 1'b0) begin  // a missing answer is left to the watchdog
      @(posedge CLK);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge CLK);
  endtask
  // counts cycles until: 0 reset phase seen, 1 reset phase over, 2 running
  task wait_lvl(input int sel);
    n = 0;
    while ((sel == 0 ? pcc !== 1'b1 : sel == 1 ? pcc !== 1'b0 : hold !== 1'b0) && n < 200) begin
      @(posedge CLK);
      n++;
    end
  endtask
  task finish_reset(input string nm, input int ticks);
    wait_lvl(1);
    check(nm, pp, 1'b0);
    wait_lvl(2);
    check(nm, n >= (ticks - 1) * DIV && n <= (ticks + 1) * DIV + 2, 1'b1);
  endtask
  // ********************************************************************
  // scenarios
  // ********************************************************************
  task test_por;
    finish_reset("por delay", SPIN);
    be <= 4'h0;
    bus(ADR_PINSEL, 1'b1, 32'h0000_00AA); // lane 0 off, write refused
    be <= 4'hF;
    bus(ADR_PINSEL, 1'b0, 0);
    check("pinsel por", q, 32'h0000_0055);
    bus(ADR_SYSTEM_MODE_CONTROL_1, 1'b0, 0);
    check("system_mode_control_1 por", q & 32'h0000_0089, 32'h0000_0000);
    bus(5'h1C, 1'b0, 0);
    check("unmapped", q, 32'h0000_0000);
    check("gpio mode", {pmode, gpio}, 2'b01);
  endtask
  task test_pin;
    bus(ADR_PINSEL, 1'b1, 32'h0000_00AA);
    @(posedge CLK);
    check("reset mode", {pmode, gpio}, 2'b10);
    sup.set_pin(1'b0);
    wait_lvl(0);
    check("pin cold", {n < 8, cold, pp}, 3'b101);
    sup.set_pin(1'b1);
    finish_reset("pin delay", SPIN);
    bus(ADR_PINSEL, 1'b0, 0);
    check("pinsel after pin", q, 32'h0000_0055);
    bus(ADR_IRQ_ST, 1'b0, 0);
    check("pin status", q[0], 1'b1);
    bus(ADR_IRQ_MK, 1'b1, 32'h0000_0001);
    @(posedge CLK);
    check("irq unmasked", irq, 1'b1);
    bus(ADR_IRQ_ST, 1'b1, 32'h0000_0001);
    @(posedge CLK);
    check("irq cleared", irq, 1'b0);
  endtask
  task test_uv;
    sup.set_uv(1'b1);
    sup.set_uv(1'b0);
    repeat (30) @(posedge CLK);
    check("uv glitch", hold, 1'b0);
    sleep <= 1'b1;
    sup.set_uv(1'b1);
    repeat (40) @(posedge CLK);
    check("uv in sleep", hold, 1'b0);
    sup.set_uv(1'b0);
    sleep <= 1'b0;
    repeat (4) @(posedge CLK);
    sup.set_uv(1'b1);
    wait_lvl(0);
    check("uv fire", n <= 5 * DIV + 8, 1'b1);
    // hold the supply low past the checker's late limit
    repeat (10) @(posedge CLK);
    sup.set_uv(1'b0);
    finish_reset("uv delay", SLVR);
    bus(ADR_SYSTEM_MODE_CONTROL_1, 1'b0, 0);
    check("uv flag", q[2], 1'b1);
    bus(ADR_SYSTEM_MODE_CONTROL_1, 1'b1, 0);
    bus(ADR_SYSTEM_MODE_CONTROL_1, 1'b1, 32'h0000_0084);
    bus(ADR_SYSTEM_MODE_CONTROL_1, 1'b0, 0);
    check("uv flag sw", q[2], 1'b0);
    check("keep bit", {q[7], keep}, 2'b11);
  endtask
  task test_wdt;
    bus(ADR_PINSEL, 1'b1, 32'h0000_00AA);
    wdt_to <= 1'b1;
    @(posedge CLK);
    wdt_to <= 1'b0;
    wait_lvl(0);
    @(posedge CLK);
    check("to flag", {n < 8, tof}, 2'b11);
    finish_reset("wdt delay", SPIN);
    check("mode kept", pmode, 1'b1);
    bus(ADR_CAUSE, 1'b1, 0);
    @(posedge CLK);
    check("to cleared", tof, 1'b0);
    bus(ADR_PINSEL, 1'b1, 32'h0000_0055);
  endtask
  task test_wctl;
    for (int i = 0; i < 3; i++) begin
      fwr <= 1'b1;
      fval <= i == 0 ? WDT_EN_ON : i == 1 ? WDT_EN_OFF : 5'h1F;
      @(posedge CLK);
      fwr <= 1'b0;
      wait_lvl(0);
      check("field reset", n < 30, i == 2);
    end
    finish_reset("wctl delay", SPIN);
    bus(ADR_SYSTEM_MODE_CONTROL_1, 1'b0, 0);
    check("wctl flag", q[0], 1'b1);
    bus(ADR_SYSTEM_MODE_CONTROL_1, 1'b1, 0);
    bus(ADR_SYSTEM_MODE_CONTROL_1, 1'b0, 0);
    check("wctl clear", q[0], 1'b0);
  endtask
  task stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence: power-on reset held five cycles, then every scenario
  initial begin
    {sys_rst, sleep, wdt_to, fwr, rd, wr} = 6'b100000;
    fval = 5'h00;
    be = 4'hF;
    adr = 5'h00;
    wd = 32'h0000_0000;
    repeat (5) @(posedge CLK);
    check("por forced", {pcc, cold, hold, pp}, 4'b1111);
    sys_rst <= 1'b0;
    test_por;
    test_pin;
    test_uv;
    test_wdt;
    test_wctl;
    stop_test;
  end
  // a hang ends the run at 30000 cycles, well beyond the under one thousand cycles it needs
  initial begin
    #300000;
    fail_count++;
    stop_test;
  end
endmodule // mrsc_reset_ctrl_bench
